/* File: common/bosg_pkg.sv */
// Notes on behaviour
// - steered mode: pwm on chosen outputs, immediately
// - sync steered: steering change waits rising event
// - sync steered: static levels apply without waiting
// - mode 000 steered, 001 sync steered
// - full bridge: one modulated, one 100%, two off
// - direction change delays modulated output by dead-band
// - forward: d modulated, a held on
// - reverse: b modulated, c held on
// - mode 010 forward, 011 reverse
// - auto restart bit picks restart method
// - after clear, hold shutdown until rising event
// - clear refused while any enabled input true
// - auto restart clears flag, resumes at rise
package bosg_pkg;

  localparam int NUM_OUT = 4;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int IRQ_W = 3;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STEER = 8'h04;
  localparam logic [7:0] OFS_SHDN = 8'h08;
  localparam logic [7:0] OFS_SDEN = 8'h0C;
  localparam logic [7:0] OFS_DBAND = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;

  // field positions
  localparam int MODE_LSB = 0;
  localparam int STEER_EN_LSB = 0;
  localparam int STEER_DAT_LSB = 4;
  localparam int SHDN_FLAG_BIT = 0;
  localparam int SHDN_ARS_BIT = 1;
  localparam int SHDN_LVL_LSB = 4;
  localparam int IRQ_SHUT_BIT = 0;
  localparam int IRQ_RESUME_BIT = 1;
  localparam int IRQ_DIR_BIT = 2;
  localparam int STAT_OUT_LSB = 0;
  localparam int STAT_PWM_BIT = 4;
  localparam int STAT_SD_LSB = 5;
  localparam int STAT_DB_BIT = 7;

  // reset values
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [3:0] STEER_EN_RST = 4'h0;
  localparam logic [3:0] STEER_DAT_RST = 4'h0;
  localparam logic [3:0] SHDN_LVL_RST = 4'h0;
  localparam logic [2:0] IRQ_RST = 3'h0;

  // codes 4..7 are reserved and behave as plain steering
  localparam logic [2:0] MODE_STEER = 3'h0;
  localparam logic [2:0] MODE_SYNC = 3'h1;
  localparam logic [2:0] MODE_FWD = 3'h2;
  localparam logic [2:0] MODE_REV = 3'h3;

  // output bit positions
  localparam int OUT_A = 0;
  localparam int OUT_B = 1;
  localparam int OUT_C = 2;
  localparam int OUT_D = 3;

  typedef enum logic [1:0] {
    SD_RUN = 2'h0,
    SD_SHUT = 2'h1,
    SD_WAIT = 2'h3
  } bosg_sd_e;

endpackage

/* File: hdl/bosg_dband.sv */
`timescale 1ns/1ns
module bosg_dband #(
  parameter int DB_W = 6
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset, active high
  input wire logic start_i, // load the delay
  input wire logic [DB_W-1:0] count_i, // delay in clocks
  output logic busy_o // delay running
);

  typedef struct packed {
    logic [DB_W-1:0] cnt;
  } bosg_dband_s;

  bosg_dband_s st_r;
  bosg_dband_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (start_i) begin
      st_nxt.cnt = count_i;
    end else if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - DB_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // a zero count gives no delay at all
  assign busy_o = (st_r.cnt != '0);

endmodule

/* File: hdl/bosg_top.sv */
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/1ns
module bosg_top #(
  parameter int NUM_SD = 8,
  parameter int DB_W = 6
) (
  input wire logic clk_i, // system clock, 250 MHz
  input wire logic rst_i, // sync reset, active high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [bosg_pkg::ADR_W-1:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [bosg_pkg::DAT_W-1:0] wb_dat_i, // write data
  output logic [bosg_pkg::DAT_W-1:0] wb_dat_o, // read data
  output logic wb_ack_o, // wishbone ack
  input wire logic rise_evt_i, // rising event pulse
  input wire logic fall_evt_i, // falling event pulse
  input wire logic [NUM_SD-1:0] sd_in_i, // shutdown sources
  output logic output_a_o, // bridge output a
  output logic output_b_o, // bridge output b
  output logic output_c_o, // bridge output c
  output logic output_d_o, // bridge output d
  output logic irq_o // level interrupt
);

  localparam int NO = bosg_pkg::NUM_OUT;
  localparam int IW = bosg_pkg::IRQ_W;

  typedef struct packed {
    logic [2:0] mode;
    logic [NO-1:0] steer_en;
    logic [NO-1:0] steer_dat;
    logic [NO-1:0] steer_act;
    logic ars;
    logic [NO-1:0] sd_lvl;
    logic [NUM_SD-1:0] sd_en;
    logic [DB_W-1:0] db_cnt;
    logic [IW-1:0] irq_stat;
    logic [IW-1:0] irq_mask;
    bosg_pkg::bosg_sd_e sd;
    logic pwm;
    logic fb_on;
    logic fb_dir;
    logic [NO-1:0] outs;
    logic ack;
    logic [bosg_pkg::DAT_W-1:0] rdat;
  } bosg_top_s;

  bosg_top_s st_r;
  bosg_top_s st_nxt;

  logic db_busy;
  logic db_start;
  logic [NO-1:0] steer_wave;
  logic [NO-1:0] sync_wave;

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] d,
    input logic [3:0] sel
  );
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{sel[i]}};
    end
    return (old & ~m) | (d & m);
  endfunction

  // per output: pwm where steered, static level elsewhere
  genvar g;
  generate
    for (g = 0; g < NO; g++) begin : g_steer
      assign steer_wave[g] = st_r.steer_en[g] ? st_r.pwm : st_r.steer_dat[g];
      assign sync_wave[g] = st_r.steer_act[g] ? st_r.pwm : st_r.steer_dat[g];
    end
  endgenerate

  bosg_dband #(
    .DB_W(DB_W)
  ) u_dband (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(db_start),
    .count_i(st_r.db_cnt),
    .busy_o(db_busy)
  );

  always_comb begin
    logic req;
    logic wr;
    logic sd_act;
    logic sw_set;
    logic sw_clr;
    logic fb;
    logic dir;
    logic dir_chg;
    logic [31:0] mg;
    logic [IW-1:0] irq_clr;
    logic [IW-1:0] irq_ev;
    logic [NO-1:0] wave;
    logic [31:0] rd;
    req = 1'b0;
    wr = 1'b0;
    sd_act = 1'b0;
    sw_set = 1'b0;
    sw_clr = 1'b0;
    fb = 1'b0;
    dir = 1'b0;
    dir_chg = 1'b0;
    mg = '0;
    irq_clr = '0;
    irq_ev = '0;
    wave = '0;
    rd = '0;
    st_nxt = st_r;
    db_start = 1'b0;

    // bus: answer one cycle after the request, write lands on the ack edge
    req = wb_cyc_i & wb_stb_i;
    wr = req & wb_we_i & st_r.ack;
    st_nxt.ack = req & ~st_r.ack;

    if (wr) begin
      unique case (wb_adr_i)
        bosg_pkg::OFS_CTRL: begin
          mg = merge(32'(st_r.mode), wb_dat_i, wb_sel_i);
          st_nxt.mode = mg[bosg_pkg::MODE_LSB +: 3];
        end
        bosg_pkg::OFS_STEER: begin
          mg = merge({24'h00_0000, st_r.steer_dat, st_r.steer_en}, wb_dat_i, wb_sel_i);
          st_nxt.steer_en = mg[bosg_pkg::STEER_EN_LSB +: NO];
          st_nxt.steer_dat = mg[bosg_pkg::STEER_DAT_LSB +: NO];
        end
        bosg_pkg::OFS_SHDN: begin
          mg = merge({24'h00_0000, st_r.sd_lvl, 4'h0}, wb_dat_i, wb_sel_i);
          st_nxt.sd_lvl = mg[bosg_pkg::SHDN_LVL_LSB +: NO];
          if (wb_sel_i[0]) begin
            st_nxt.ars = wb_dat_i[bosg_pkg::SHDN_ARS_BIT];
            sw_set = wb_dat_i[bosg_pkg::SHDN_FLAG_BIT];
            sw_clr = ~wb_dat_i[bosg_pkg::SHDN_FLAG_BIT];
          end
        end
        bosg_pkg::OFS_SDEN: begin
          mg = merge(32'(st_r.sd_en), wb_dat_i, wb_sel_i);
          st_nxt.sd_en = mg[NUM_SD-1:0];
        end
        bosg_pkg::OFS_DBAND: begin
          mg = merge(32'(st_r.db_cnt), wb_dat_i, wb_sel_i);
          st_nxt.db_cnt = mg[DB_W-1:0];
        end
        bosg_pkg::OFS_IRQ_STAT: begin
          if (wb_sel_i[0]) begin
            irq_clr = wb_dat_i[IW-1:0];
          end
        end
        bosg_pkg::OFS_IRQ_MASK: begin
          mg = merge(32'(st_r.irq_mask), wb_dat_i, wb_sel_i);
          st_nxt.irq_mask = mg[IW-1:0];
        end
        default: begin
          mg = '0;
        end
      endcase
    end

    // pwm built from events; a falling event wins over a rising one
    if (fall_evt_i) begin
      st_nxt.pwm = 1'b0;
    end else if (rise_evt_i) begin
      st_nxt.pwm = 1'b1;
    end

    // steering enables: sync mode waits for a rising event
    if (st_r.mode == bosg_pkg::MODE_SYNC) begin
      if (rise_evt_i) begin
        st_nxt.steer_act = st_r.steer_en;
      end
    end else begin
      st_nxt.steer_act = st_r.steer_en;
    end

    // direction tracking across full-bridge modes only
    fb = (st_r.mode == bosg_pkg::MODE_FWD) | (st_r.mode == bosg_pkg::MODE_REV);
    dir = (st_r.mode == bosg_pkg::MODE_REV);
    dir_chg = fb & st_r.fb_on & (dir != st_r.fb_dir);
    st_nxt.fb_on = fb;
    if (fb) begin
      st_nxt.fb_dir = dir;
    end
    db_start = dir_chg;

    // shutdown: a true input always wins over a software clear
    sd_act = |(sd_in_i & st_r.sd_en);
    unique case (st_r.sd)
      bosg_pkg::SD_RUN: begin
        if (sd_act | sw_set) begin
          st_nxt.sd = bosg_pkg::SD_SHUT;
        end
      end
      bosg_pkg::SD_SHUT: begin
        if (!sd_act && (st_r.ars || sw_clr)) begin
          st_nxt.sd = bosg_pkg::SD_WAIT;
        end
      end
      bosg_pkg::SD_WAIT: begin
        if (sd_act | sw_set) begin
          st_nxt.sd = bosg_pkg::SD_SHUT;
        end else if (rise_evt_i) begin
          st_nxt.sd = bosg_pkg::SD_RUN;
        end
      end
      default: begin
        st_nxt.sd = bosg_pkg::SD_SHUT;
      end
    endcase

    // output selection by mode
    unique case (st_r.mode)
      bosg_pkg::MODE_SYNC: begin
        wave = sync_wave;
      end
      bosg_pkg::MODE_FWD: begin
        wave[bosg_pkg::OUT_A] = 1'b1;
        wave[bosg_pkg::OUT_D] = st_r.pwm & ~db_busy;
      end
      bosg_pkg::MODE_REV: begin
        wave[bosg_pkg::OUT_C] = 1'b1;
        wave[bosg_pkg::OUT_B] = st_r.pwm & ~db_busy;
      end
      default: begin
        wave = steer_wave;
      end
    endcase
    // the direction switch itself already blanks the modulated leg
    if (dir_chg) begin
      wave[bosg_pkg::OUT_B] = 1'b0;
      wave[bosg_pkg::OUT_D] = 1'b0;
    end
    if (st_r.sd != bosg_pkg::SD_RUN) begin
      st_nxt.outs = st_r.sd_lvl;
    end else begin
      st_nxt.outs = wave;
    end

    // sticky events, set wins over the write-one clear
    irq_ev[bosg_pkg::IRQ_SHUT_BIT] =
      (st_r.sd != bosg_pkg::SD_SHUT) & (st_nxt.sd == bosg_pkg::SD_SHUT);
    irq_ev[bosg_pkg::IRQ_RESUME_BIT] =
      (st_r.sd == bosg_pkg::SD_WAIT) & (st_nxt.sd == bosg_pkg::SD_RUN);
    irq_ev[bosg_pkg::IRQ_DIR_BIT] = dir_chg;
    st_nxt.irq_stat = (st_r.irq_stat & ~irq_clr) | irq_ev;

    // read data is captured when the request is first seen
    unique case (wb_adr_i)
      bosg_pkg::OFS_CTRL: begin
        rd = 32'(st_r.mode);
      end
      bosg_pkg::OFS_STEER: begin
        rd = {24'h00_0000, st_r.steer_dat, st_r.steer_en};
      end
      bosg_pkg::OFS_SHDN: begin
        rd = {24'h00_0000, st_r.sd_lvl, 2'h0, st_r.ars,
              st_r.sd == bosg_pkg::SD_SHUT};
      end
      bosg_pkg::OFS_SDEN: begin
        rd = 32'(st_r.sd_en);
      end
      bosg_pkg::OFS_DBAND: begin
        rd = 32'(st_r.db_cnt);
      end
      bosg_pkg::OFS_IRQ_STAT: begin
        rd = 32'(st_r.irq_stat);
      end
      bosg_pkg::OFS_IRQ_MASK: begin
        rd = 32'(st_r.irq_mask);
      end
      bosg_pkg::OFS_STATUS: begin
        rd = {24'h00_0000, db_busy, st_r.sd, st_r.pwm, st_r.outs};
      end
      default: begin
        rd = '0;
      end
    endcase
    if (req & ~st_r.ack & ~wb_we_i) begin
      st_nxt.rdat = rd;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.mode <= bosg_pkg::CTRL_RST;
      st_r.steer_en <= bosg_pkg::STEER_EN_RST;
      st_r.steer_dat <= bosg_pkg::STEER_DAT_RST;
      st_r.steer_act <= bosg_pkg::STEER_EN_RST;
      st_r.sd_lvl <= bosg_pkg::SHDN_LVL_RST;
      st_r.irq_stat <= bosg_pkg::IRQ_RST;
      st_r.irq_mask <= bosg_pkg::IRQ_RST;
      st_r.sd <= bosg_pkg::SD_RUN;
      st_r.outs <= bosg_pkg::STEER_DAT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_dat_o = st_r.rdat;
  assign wb_ack_o = st_r.ack;
  assign output_a_o = st_r.outs[bosg_pkg::OUT_A];
  assign output_b_o = st_r.outs[bosg_pkg::OUT_B];
  assign output_c_o = st_r.outs[bosg_pkg::OUT_C];
  assign output_d_o = st_r.outs[bosg_pkg::OUT_D];
  // interrupt stays high while any unmasked sticky bit is set
  assign irq_o = |(st_r.irq_stat & st_r.irq_mask);

endmodule

/* File: dv/bosg_bridge_model.sv */
`timescale 1ns/1ns
module bosg_bridge_model (
  input wire logic clk_i, // system clock
  input wire logic [3:0] gate_i, // drive levels d,c,b,a
  input wire logic [7:0] sd_i, // fault lines from the bench
  output logic [7:0] sd_o // fault lines to the block
);
  logic trip_r;
  // a leg with both switches on trips the overcurrent detector
  always_ff @(posedge clk_i) begin
    trip_r <= (gate_i[0] & gate_i[1]) | (gate_i[2] & gate_i[3]);
  end
  assign sd_o = {sd_i[7:1], sd_i[0] | trip_r};
endmodule

/* File: dv/bosg_top_checker.sv */
`timescale 1ns/1ns
module bosg_top_checker #(
  parameter int NUM_SD = 8,
  parameter int DB_W = 6
) (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [bosg_pkg::ADR_W-1:0] wb_adr_i, // address
  input wire logic [bosg_pkg::DAT_W-1:0] wb_dat_i, // write data
  input wire logic wb_ack_o, // ack
  input wire logic rise_evt_i, // rise event
  input wire logic fall_evt_i, // fall event
  input wire logic [NUM_SD-1:0] sd_in_i, // shutdown lines
  input wire logic output_a_o, // pin a
  input wire logic output_b_o, // pin b
  input wire logic output_c_o, // pin c
  input wire logic output_d_o // pin d
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wr, clr, sdon, pwm_r, ars_r, held_r, wait_r;
  logic [2:0] mode_r;
  logic [3:0] pins, en, lvl_r, eff_r, exp_r;
  logic [7:0] st_r, q_r;
  logic [NUM_SD-1:0] sden_r;
  logic [DB_W-1:0] db_r;
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign clr = wr && wb_adr_i == bosg_pkg::OFS_SHDN && !wb_dat_i[0];
  assign sdon = |(sd_in_i & sden_r);
  assign pins = {output_d_o, output_c_o, output_b_o, output_a_o};
  // sync steering shows the enables latched at the last rising event
  assign en = mode_r == bosg_pkg::MODE_SYNC ? eff_r : st_r[3:0];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= bosg_pkg::CTRL_RST;
      st_r <= 8'h00;
      sden_r <= '0;
      db_r <= '1;
      {lvl_r, ars_r} <= 5'h00;
      {pwm_r, held_r, wait_r} <= 3'h0;
      eff_r <= 4'h0;
      exp_r <= 4'h0;
      q_r <= 8'h00;
    end else begin
      if (wr && wb_adr_i == bosg_pkg::OFS_CTRL) mode_r <= wb_dat_i[2:0];
      if (wr && wb_adr_i == bosg_pkg::OFS_STEER) st_r <= wb_dat_i[7:0];
      if (wr && wb_adr_i == bosg_pkg::OFS_SDEN) sden_r <= wb_dat_i[NUM_SD-1:0];
      if (wr && wb_adr_i == bosg_pkg::OFS_DBAND) db_r <= wb_dat_i[DB_W-1:0];
      if (wr && wb_adr_i == bosg_pkg::OFS_SHDN) {lvl_r, ars_r} <= {wb_dat_i[7:4], wb_dat_i[1]};
      pwm_r <= !fall_evt_i && (rise_evt_i || pwm_r);
      held_r <= sdon || (held_r && !(wait_r && rise_evt_i));
      wait_r <= held_r && !sdon && !(wait_r && rise_evt_i) && (wait_r || ars_r || clr);
      if (mode_r != bosg_pkg::MODE_SYNC || rise_evt_i) eff_r <= st_r[3:0];
      if (held_r) exp_r <= lvl_r;
      else if (mode_r == bosg_pkg::MODE_FWD) exp_r <= {pwm_r, 3'h1};
      else if (mode_r == bosg_pkg::MODE_REV) exp_r <= {2'h1, pwm_r, 1'b0};
      else exp_r <= (en & {4{pwm_r}}) | (~en & st_r[7:4]);
      q_r <= (wr && wb_adr_i == bosg_pkg::OFS_CTRL) ? 8'h00 : q_r + 8'(q_r != 8'hff);
    end
  end
  chk_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged in the next cycle");
  chk_ack_drop: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_steer_pins: assert property (q_r > 8'h02 && mode_r[2:1] != 2'h1
    |-> pins == exp_r) else $error("steered pins wrong");
  chk_fwd_pins: assert property (mode_r == bosg_pkg::MODE_FWD
    && int'(q_r) > int'(db_r) + 3 |-> pins == exp_r) else $error("forward pins wrong");
  chk_rev_pins: assert property (mode_r == bosg_pkg::MODE_REV
    && int'(q_r) > int'(db_r) + 3 |-> pins == exp_r) else $error("reverse pins wrong");
  chk_db_hold: assert property (wr && wb_adr_i == bosg_pkg::OFS_CTRL && !held_r
    && wb_dat_i[2:0] == bosg_pkg::MODE_REV && mode_r == bosg_pkg::MODE_FWD && db_r > 3
    |=> !output_b_o [*3]) else $error("no dead band on direction change");
  chk_sd_force: assert property (sdon |-> ##2 pins == lvl_r)
    else $error("shutdown levels not forced");
  chk_hold_shut: assert property (held_r |=> pins == lvl_r)
    else $error("left shutdown too early");
  chk_resume: assert property (wait_r && rise_evt_i && !sdon |-> ##2 pins == exp_r)
    else $error("no resume at rising event");
  cover property (rise_evt_i && mode_r == bosg_pkg::MODE_SYNC);
  cover property (wait_r && rise_evt_i);
  cover property (wr && mode_r == bosg_pkg::MODE_FWD && wb_dat_i[2:0] == bosg_pkg::MODE_REV);
endmodule

bind bosg_top bosg_top_checker #(.NUM_SD(NUM_SD), .DB_W(DB_W)) chk_u (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .rise_evt_i(rise_evt_i),
  .fall_evt_i(fall_evt_i), .sd_in_i(sd_in_i), .output_a_o(output_a_o),
  .output_b_o(output_b_o), .output_c_o(output_c_o), .output_d_o(output_d_o));

/* File: dv/bosg_top_tb_top.sv */
`timescale 1ns/1ns
module bosg_top_tb_top;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, rise = 0, fall = 0, flt = 0;
  logic probe = 0, a, b, c, d, ack, irq;
  logic [6:0] rnd = 7'h00;
  logic [7:0] adr = 8'h00, sd_in;
  logic [31:0] wdat = 32'h0000_0000, rdo, ev, seen;
  logic [31:0] expq[$];
  int fail_count = 0, comparisons = 0;
  bosg_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdo),
    .wb_ack_o(ack), .rise_evt_i(rise), .fall_evt_i(fall), .sd_in_i(sd_in),
    .output_a_o(a), .output_b_o(b), .output_c_o(c), .output_d_o(d), .irq_o(irq));
  bosg_bridge_model pm_u (.clk_i(clk_i), .gate_i({d, c, b, a}), .sd_i({rnd, flt}),
    .sd_o(sd_in));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  // noise on disabled shutdown lines must never matter
  always @(posedge clk_i) rnd <= 7'($urandom);
  always @(posedge clk_i) begin
    if (probe || (ack === 1'b1 && !we)) begin
      seen = probe ? {27'h0, irq, d, c, b, a} : rdo;
      ev = expq.size() > 0 ? expq.pop_front() : 'x;
      comparisons++;
      if (seen !== ev) begin
        fail_count++;
        $display("mismatch %s expected %h seen %h", probe ? "pins" : "rdata", ev, seen);
      end
    end
  end
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] dt);
    {cyc, stb, we, adr, wdat} <= {2'h3, w, ad, dt};
    // no local limit: a missing ack is left for the watchdog to catch
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    {cyc, stb} <= 2'h0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    expq.push_back(e);
    bus(0, ad, 32'h0000_0000);
  endtask
  task automatic pins(input logic [4:0] e);
    expq.push_back({27'h0, e});
    @(posedge clk_i);
    probe <= 1;
    @(posedge clk_i);
    probe <= 0;
  endtask
  task automatic evt(input logic r, input logic f);
    {rise, fall} <= {r, f};
    @(posedge clk_i);
    {rise, fall} <= 2'h0;
    @(posedge clk_i);
  endtask
  task automatic close_out;
    $display("counts: %0d compared, %0d mismatched", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #40000;
    fail_count++;
    close_out;
  end
  initial begin
    logic [31:0] v;
    void'($urandom(11));
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    rd(bosg_pkg::OFS_CTRL, 32'h0000_0000);
    bus(1, bosg_pkg::OFS_SDEN, 32'h0000_0001);
    bus(1, bosg_pkg::OFS_DBAND, 32'h0000_0004);
    bus(1, bosg_pkg::OFS_SHDN, 32'h0000_00a0);
    bus(1, bosg_pkg::OFS_STEER, 32'h0000_0041);
    evt(1, 0);
    pins(5'h05);
    evt(0, 1);
    pins(5'h04);
    bus(1, bosg_pkg::OFS_STEER, 32'h0000_0080);
    pins(5'h08);
    $display("steered test done");
    bus(1, bosg_pkg::OFS_CTRL, 32'h0000_0001);
    evt(1, 0);
    bus(1, bosg_pkg::OFS_STEER, 32'h0000_0081);
    pins(5'h08);
    bus(1, bosg_pkg::OFS_STEER, 32'h0000_0001);
    pins(5'h00);
    evt(1, 0);
    pins(5'h01);
    $display("sync test done");
    bus(1, bosg_pkg::OFS_CTRL, 32'h0000_0002);
    pins(5'h09);
    evt(0, 1);
    pins(5'h01);
    evt(1, 0);
    bus(1, bosg_pkg::OFS_CTRL, 32'h0000_0003);
    pins(5'h04);
    repeat (8) @(posedge clk_i);
    pins(5'h06);
    bus(1, bosg_pkg::OFS_CTRL, 32'h0000_0002);
    pins(5'h01);
    repeat (8) @(posedge clk_i);
    pins(5'h09);
    $display("bridge test done");
    bus(1, bosg_pkg::OFS_CTRL, 32'h0000_0000);
    flt <= 1;
    repeat (3) @(posedge clk_i);
    pins(5'h0a);
    bus(1, bosg_pkg::OFS_SHDN, 32'h0000_00a0);
    pins(5'h0a);
    rd(bosg_pkg::OFS_SHDN, 32'h0000_00a1);
    flt <= 0;
    repeat (3) @(posedge clk_i);
    pins(5'h0a);
    bus(1, bosg_pkg::OFS_SHDN, 32'h0000_00a0);
    pins(5'h0a);
    evt(1, 0);
    pins(5'h01);
    bus(1, bosg_pkg::OFS_SHDN, 32'h0000_00a2);
    flt <= 1;
    repeat (3) @(posedge clk_i);
    flt <= 0;
    repeat (3) @(posedge clk_i);
    pins(5'h0a);
    rd(bosg_pkg::OFS_SHDN, 32'h0000_00a2);
    evt(1, 0);
    pins(5'h01);
    rd(bosg_pkg::OFS_STATUS, 32'h0000_0011);
    $display("shutdown test done");
    rd(bosg_pkg::OFS_IRQ_STAT, 32'h0000_0007);
    pins(5'h01);
    bus(1, bosg_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    pins(5'h11);
    bus(1, bosg_pkg::OFS_IRQ_STAT, 32'h0000_0001);
    pins(5'h01);
    rd(bosg_pkg::OFS_IRQ_STAT, 32'h0000_0006);
    bus(1, 8'h40, 32'hffff_ffff);
    rd(8'h40, 32'h0000_0000);
    v = 32'($urandom_range(63));
    bus(1, bosg_pkg::OFS_DBAND, v);
    rd(bosg_pkg::OFS_DBAND, v);
    // a reserved mode code must fall back to plain steering
    bus(1, bosg_pkg::OFS_CTRL, 32'h0000_0004);
    pins(5'h01);
    // both events in one cycle: the falling one wins
    evt(1, 1);
    pins(5'h00);
    $display("register test done");
    close_out;
  end
endmodule
